// File: src/bcs_top.sv
// command sequencer top: AXI4-Lite register file, init, clear and run control
//
// Overview of operation
// - hardware reset whitens the line memory
// - hardware reset sets typical-prediction line flag
// - table clear takes 1025 or 4097 clocks
// - completion sets end flag, interrupt if enabled
// - status shows end, marker, overflow flags
// - external context ignores geometry and options
// - first temporary-stop run: count plus/minus one
// - restarted runs use exact line count
// - command bit d0 starts trailer run
// - command bit d3 starts stopping run
// - SDNORM keeps state, SDRST reinitialises
module bcs_top import bcs_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic intr_q,
    output logic line_tp_q, // typical-prediction line flag
    output logic busy_q // whitening, run or clear in progress
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] sys_q, para_q, cmd_q, ienb_q, mset_q, mdet_q, conv_q;
    logic [15:0] pel_q, lset_q;
    logic stat_end_q, stat_mark_q, stat_ovf_q;
    bcs_state_t state_q;
    logic [12:0] addr_q; // sweep address for line memory or table
    logic first_tstop_q; // next start is first of a chain
    logic last_sdrst_q; // previous stripe ended with reset marker
    logic run_start; // pulse into line counter
    logic [15:0] lcnt;
    logic reached, reached_raw; // raw flag still shows the last run in the start cycle
    logic ext_ctx;
    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic [7:0] aw_q; // latched write address
    logic aw_have_q, w_have_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_fire;
    logic wr_ok;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ok = wr_fire && ws_q[0];
    assign ext_ctx = sys_q[SYS_CTX];
    assign reached = reached_raw && !run_start; // no stale end on a fresh start

    // capture address and data in either order
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped offsets answer slave error
                s_axi_bresp <= (aw_q > OFF_CTRL || aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel, one cycle after address
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                OFF_SYS: s_axi_rdata <= {24'h000000, sys_q};
                OFF_PARA: s_axi_rdata <= {24'h000000, para_q};
                OFF_CMD: s_axi_rdata <= {24'h000000, cmd_q};
                // three status flags
                OFF_STAT: s_axi_rdata <= {29'h00000000, stat_ovf_q, stat_mark_q, stat_end_q};
                OFF_IENB: s_axi_rdata <= {24'h000000, ienb_q};
                OFF_PEL: s_axi_rdata <= {16'h0000, pel_q};
                OFF_LSET: s_axi_rdata <= {16'h0000, lset_q};
                OFF_LCNT: s_axi_rdata <= {16'h0000, lcnt};
                OFF_MSET: s_axi_rdata <= {24'h000000, mset_q};
                OFF_MDET: s_axi_rdata <= {24'h000000, mdet_q};
                OFF_CONV: s_axi_rdata <= {24'h000000, conv_q};
                OFF_LINE, OFF_CTRL: s_axi_rdata <= 32'h00000000;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2; // unmapped
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic hwrst;
    assign hwrst = sys_q[SYS_HWRST];

    // plain setup writes; the system register stays writable while its reset bit holds the others at reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_q <= REG_RST;
            para_q <= REG_RST;
            ienb_q <= REG_RST;
            pel_q <= 16'h0000;
            lset_q <= 16'h0000;
            mset_q <= REG_RST;
            conv_q <= REG_RST;
        end else if (hwrst && !(wr_ok && aw_q == OFF_SYS)) begin
            // bit held: others stay at reset values
            para_q <= REG_RST;
            ienb_q <= REG_RST;
            pel_q <= 16'h0000;
            lset_q <= 16'h0000;
            mset_q <= REG_RST;
            conv_q <= REG_RST;
        end else if (wr_ok) begin
            case (aw_q)
                OFF_SYS: sys_q <= wd_q[7:0];
                OFF_PARA: para_q <= wd_q[7:0];
                OFF_IENB: ienb_q <= wd_q[7:0];
                OFF_PEL: pel_q <= wd_q[15:0];
                OFF_LSET: lset_q <= wd_q[15:0];
                OFF_MSET: mset_q <= wd_q[7:0];
                OFF_CONV: conv_q <= wd_q[7:0];
                default: sys_q <= sys_q;
            endcase
        end else if (state_q == BCS_DONE && last_sdrst_q) begin
            para_q <= {para_q[7], PARA_AT_DEFAULT};
        end
    end

    // ----------------------------------------------------------------
    // command decode and sequencing
    // ----------------------------------------------------------------
    logic cmd_wr;
    logic line_evt;
    logic core_done;
    assign cmd_wr = wr_ok && aw_q == OFF_CMD && !hwrst;
    assign line_evt = wr_ok && aw_q == OFF_LINE && state_q == BCS_RUN;
    assign core_done = wr_ok && aw_q == OFF_CTRL && wd_q[0] && state_q == BCS_RUN;

    // clear sweep, runs and temporary stops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= BCS_LMINIT;
            addr_q <= 13'h0000;
            cmd_q <= REG_RST;
            first_tstop_q <= 1'b1;
            run_start <= 1'b0;
        end else begin
            run_start <= 1'b0;
            if (hwrst) begin
                state_q <= BCS_LMINIT;
                addr_q <= 13'h0000;
                cmd_q <= REG_RST;
                first_tstop_q <= 1'b1;
            end else begin
                if (cmd_wr) begin
                    cmd_q <= wd_q[7:0];
                end
                case (state_q)
                    BCS_LMINIT: begin
                        // white reference line
                        addr_q <= 13'(addr_q + 13'h0001);
                        if (addr_q == 13'(LINE_WORDS - 1)) begin
                            state_q <= BCS_IDLE;
                            addr_q <= 13'h0000;
                        end
                    end
                    BCS_IDLE: begin
                        if (cmd_wr && wd_q[7:0] == CMD_CODE_CLEAR) begin
                            state_q <= BCS_CLEAR; // table clear command
                            addr_q <= 13'h0000;
                        end else if (cmd_wr && wd_q[7:0] == CMD_CODE_RUN) begin
                            state_q <= BCS_RUN;
                            run_start <= 1'b1;
                            first_tstop_q <= 1'b1;
                        end else if (cmd_wr && wd_q[7:0] == CMD_CODE_TSTOP) begin
                            state_q <= BCS_RUN;
                            run_start <= 1'b1;
                            first_tstop_q <= 1'b1;
                        end
                    end
                    BCS_CLEAR: begin
                        addr_q <= 13'(addr_q + 13'h0001);
                        if (addr_q == (ext_ctx ? 13'(CLR_EXT_WORDS) : 13'(CLR_INT_WORDS))) begin
                            state_q <= BCS_HOLD; // waits for zero command
                        end
                    end
                    BCS_RUN: begin
                        if ((cmd_q == CMD_CODE_TSTOP || cmd_q == CMD_CODE_RESTART) && reached) begin
                            state_q <= BCS_HOLD;
                            first_tstop_q <= 1'b0;
                        end else if (core_done || (cmd_q == CMD_CODE_RUN && reached)) begin
                            state_q <= BCS_DONE;
                        end
                    end
                    BCS_HOLD: begin
                        if (cmd_wr && wd_q[7:0] == CMD_CODE_RESTART) begin
                            state_q <= BCS_RUN;
                            run_start <= 1'b1;
                        end else if (cmd_wr && wd_q[7:0] == CMD_CODE_RUN) begin
                            state_q <= BCS_RUN;
                            run_start <= 1'b1;
                        end else if (cmd_wr && wd_q[7:0] == REG_RST) begin
                            state_q <= BCS_IDLE;
                            addr_q <= 13'h0000;
                        end
                    end
                    BCS_DONE: begin
                        state_q <= BCS_IDLE;
                        first_tstop_q <= 1'b1;
                    end
                    default: state_q <= BCS_IDLE;
                endcase
            end
        end
    end

    // busy indication
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b1;
        end else begin
            busy_q <= (state_q == BCS_LMINIT || state_q == BCS_CLEAR || state_q == BCS_RUN);
        end
    end

    // ----------------------------------------------------------------
    // status flags: set wins over clear
    // ----------------------------------------------------------------
    logic end_evt;
    assign end_evt = (state_q == BCS_CLEAR && addr_q ==
        (ext_ctx ? 13'(CLR_EXT_WORDS) : 13'(CLR_INT_WORDS)))
        || (state_q == BCS_RUN && (core_done || reached));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_end_q <= 1'b0;
            stat_mark_q <= 1'b0;
            stat_ovf_q <= 1'b0;
            mdet_q <= REG_RST;
            last_sdrst_q <= 1'b0;
        end else if (hwrst) begin
            stat_end_q <= 1'b0;
            stat_mark_q <= 1'b0;
            stat_ovf_q <= 1'b0;
            mdet_q <= REG_RST;
        end else begin
            if (end_evt) begin
                stat_end_q <= 1'b1;
            end else if (run_start || (state_q == BCS_IDLE && cmd_wr)) begin
                stat_end_q <= 1'b0;
            end
            if (wr_ok && aw_q == OFF_CTRL && wd_q[1] && sys_q[SYS_MODE]) begin
                stat_mark_q <= 1'b1; // decoder found a marker
                mdet_q <= wd_q[15:8];
                last_sdrst_q <= (wd_q[15:8] == MARK_SDRST);
            end else if (run_start) begin
                stat_mark_q <= 1'b0;
            end
            if (wr_ok && aw_q == OFF_CTRL && wd_q[2]) begin
                stat_ovf_q <= 1'b1;
            end else if (run_start) begin
                stat_ovf_q <= 1'b0;
            end
            if (state_q == BCS_DONE && !sys_q[SYS_MODE]) begin
                last_sdrst_q <= (mset_q == MARK_SDRST); // coder emitted marker
            end
        end
    end

    // interrupt and typical-prediction line flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intr_q <= 1'b0;
            line_tp_q <= 1'b1;
        end else begin
            intr_q <= stat_end_q && ienb_q[IENB_END];
            if (hwrst) begin
                line_tp_q <= 1'b1;
            end else if (run_start && !ext_ctx) begin
                line_tp_q <= conv_q[CONV_TP] ? line_tp_q : 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // line memory whitening and line counter
    // ----------------------------------------------------------------
    logic lm_we;
    assign lm_we = state_q == BCS_LMINIT
        || (run_start && !ext_ctx && !conv_q[CONV_LI] && last_sdrst_q);

    bcs_ram #(.AW(10), .DW(8)) u_line (
        .core_clk(core_clk),
        .we(lm_we),
        .addr(addr_q[9:0]),
        .wdata(8'h00),
        .rdata()
    );

    bcs_lines u_lines (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(run_start),
        .first_tstop(first_tstop_q && cmd_q == CMD_CODE_TSTOP),
        .decode(sys_q[SYS_MODE]),
        .lset(ext_ctx ? 16'hFFFF : lset_q),
        .line_evt(line_evt),
        .count_q(lcnt),
        .reached_q(reached_raw)
    );
endmodule

// File: src/bcs_pkg.sv
// package: register map, fields, commands and timing constants of the command sequencer
package bcs_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_SYS = 8'h00; // system setup register
    localparam logic [7:0] OFF_PARA = 8'h04; // parameter setup register
    localparam logic [7:0] OFF_CMD = 8'h08; // command register
    localparam logic [7:0] OFF_STAT = 8'h0C; // status register
    localparam logic [7:0] OFF_IENB = 8'h10; // interrupt enable register
    localparam logic [7:0] OFF_PEL = 8'h14; // pixels per line
    localparam logic [7:0] OFF_LSET = 8'h18; // lines to process
    localparam logic [7:0] OFF_LCNT = 8'h1C; // lines processed
    localparam logic [7:0] OFF_MSET = 8'h20; // end marker for coding
    localparam logic [7:0] OFF_MDET = 8'h24; // marker detected in decoding
    localparam logic [7:0] OFF_CONV = 8'h28; // function options register
    localparam logic [7:0] OFF_LINE = 8'h2C; // line event input strobe (write)
    localparam logic [7:0] OFF_CTRL = 8'h30; // core-status injection (write)
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SYS_HWRST = 0; // hardware reset bit
    localparam int SYS_CTX = 3; // context mode: 1 external
    localparam int SYS_MODE = 1; // mode lsb: 1 decoding
    localparam int CMD_RUN = 0; // run to end of trailer
    localparam int CMD_RESTART = 1; // restart after temporary stop
    localparam logic [7:0] CMD_CODE_CLEAR = 8'h02; // table clear, held until zero command
    localparam int CMD_TSTOP = 3; // run with temporary stop
    localparam int STAT_END = 0; // end of processing
    localparam int STAT_MARK = 1; // marker detected
    localparam int STAT_OVF = 2; // stack counter overflow
    localparam int IENB_END = 0; // end interrupt enable
    localparam int CONV_LI = 6; // line_memory_init_inhibit
    localparam int CONV_TP = 7; // typical_prediction_enable
    localparam logic [7:0] CMD_CODE_RUN = 8'h01;
    localparam logic [7:0] CMD_CODE_RESTART = 8'h0A;
    localparam logic [7:0] CMD_CODE_TSTOP = 8'h08;
    localparam logic [7:0] MARK_SDRST = 8'h03;
    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [6:0] PARA_AT_DEFAULT = 7'h00;
    localparam int CLR_INT_WORDS = 1024;
    localparam int CLR_EXT_WORDS = 4096;
    localparam int LINE_WORDS = 1024; // line memory depth
    localparam int HWRST_MIN_NS = 100;
    localparam int CLK_PERIOD_NS = 8;
    localparam int HWRST_MIN_CYC = (HWRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        BCS_IDLE, BCS_LMINIT, BCS_CLEAR, BCS_RUN, BCS_HOLD, BCS_DONE
    } bcs_state_t;
endpackage

// File: src/bcs_ram.sv
// small single-port memory with registered read data
module bcs_ram import bcs_pkg::*; #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // storage array, contents undefined until cleared
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write and registered read
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// File: src/bcs_lines.sv
// line counter: tracks lines processed and target for each run
module bcs_lines import bcs_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start, // pulse: new run begins
    input wire logic first_tstop, // first run of a temporary-stop chain
    input wire logic decode, // decoding mode
    input wire logic [15:0] lset, // programmed line count
    input wire logic line_evt, // pulse: one line moved
    output logic [15:0] count_q, // lines processed
    output logic reached_q // target reached
);
    // ----------------------------------------------------------------
    // target adjustment
    // ----------------------------------------------------------------
    logic [15:0] target_q; // lines required in this run

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            target_q <= 16'h0000;
        end else if (start) begin
            // first chained run: coding takes one more, decoding one fewer
            if (first_tstop && !decode) begin
                target_q <= 16'(lset + 16'h0001);
            end else if (first_tstop && decode) begin
                target_q <= 16'(lset - 16'h0001);
            end else begin
                target_q <= lset;
            end
        end
    end

    // count lines, cleared by every start
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= 16'h0000;
            reached_q <= 1'b0;
        end else if (start) begin
            count_q <= 16'h0000;
            reached_q <= 1'b0;
        end else if (line_evt && !reached_q) begin
            count_q <= 16'(count_q + 16'h0001);
            reached_q <= (16'(count_q + 16'h0001) >= target_q);
        end
    end
endmodule

// File: verification/bcs_checker.sv
// checker: port-level properties of the command sequencer top
module bcs_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic intr_q,
    input wire logic line_tp_q,
    input wire logic busy_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_tp_reset: assert property ($rose(rst_b) |-> line_tp_q)
        else $error("line flag low after reset");
    chk_white_busy: assert property ($rose(rst_b) |-> busy_q [*8])
        else $error("busy low while whitening");
    chk_intr_idle: assert property ($rose(intr_q) |-> !busy_q)
        else $error("interrupt rose while busy");
    chk_intr_reset: assert property ($rose(rst_b) |-> !intr_q)
        else $error("interrupt high after reset");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken before answer");
    // main scenarios seen
    cover property ($fell(busy_q));
    cover property ($rose(intr_q));
    cover property ($rose(busy_q));
endmodule

bind bcs_top bcs_checker u_chk (.core_clk, .rst_b, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .intr_q, .line_tp_q, .busy_q);

// File: verification/bcs_host.sv
// host model: AXI4-Lite master, one register cycle at a time
module bcs_host (
    input wire logic core_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    // idle bus from time zero
    initial begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
    end
    // write: address and data together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask
    // read: rready held until the answer, data taken at that edge
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rdat = rdata;
        resp = rresp;
    endtask
endmodule

// File: verification/bilevel_codec_command_sequencer_test.sv
// testbench: register sequences for init, clear, runs and status
module bilevel_codec_command_sequencer_test import bcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, intr, tp, busy;
    int err_count = 0;
    int cmp_count = 0;
    int n, m;
    bcs_host host (.core_clk(core_clk));
    bcs_top dut (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(host.awaddr),
        .s_axi_awvalid(host.awvalid), .s_axi_awready(host.awready), .s_axi_wdata(host.wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(host.wvalid), .s_axi_wready(host.wready),
        .s_axi_bresp(host.bresp), .s_axi_bvalid(host.bvalid), .s_axi_bready(host.bready),
        .s_axi_araddr(host.araddr), .s_axi_arvalid(host.arvalid),
        .s_axi_arready(host.arready), .s_axi_rdata(host.rdata), .s_axi_rresp(host.rresp),
        .s_axi_rvalid(host.rvalid), .s_axi_rready(host.rready), .intr_q(intr),
        .line_tp_q(tp), .busy_q(busy));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bounded wait for busy to fall, n counts the edges
    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (busy === 1'b1 && n < 6000);
    endtask
    task automatic start(input logic [7:0] sys, input logic [7:0] cmd);
        if (cmd !== CMD_CODE_RESTART) begin
            host.wr(OFF_CMD, 32'h0);
            host.wr(OFF_SYS, {24'h0, sys});
        end
        host.wr(OFF_IENB, 32'h1);
        host.wr(OFF_CMD, {24'h0, cmd});
    endtask
    // one run: the last line event must end it, not an earlier one
    task automatic run(input logic [7:0] sys, input logic [7:0] cmd, input int lines);
        start(sys, cmd);
        repeat (lines - 1) host.wr(OFF_LINE, 32'h1);
        check("running", busy, 1);
        host.wr(OFF_LINE, 32'h1);
        wait_idle();
        check("stopped", busy, 0);
        host.rd(OFF_LCNT);
        check("lines", host.rdat, lines);
        host.rd(OFF_STAT);
        check("end", host.rdat[0], 1);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // watchdog, over three times the expected run
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
    initial begin
        rst_b = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        check("tp", tp, 1);
        wait_idle();
        check("white", n + 8 > LINE_WORDS && n < LINE_WORDS + 8, 1);
        host.wr(OFF_SYS, 32'h1);
        repeat (HWRST_MIN_CYC) @(posedge core_clk);
        host.wr(OFF_SYS, 32'h0);
        check("tp", tp, 1);
        wait_idle();
        host.rd(OFF_STAT);
        check("stat", host.rdat, 0);
        host.rd(8'h40);
        check("unmapped", host.resp, 2);
        // internal then external table clear
        for (int i = 0; i < 2; i++) begin
            start(i ? 8'h08 : 8'h00, CMD_CODE_CLEAR);
            wait_idle();
            m = i ? CLR_EXT_WORDS : CLR_INT_WORDS;
            check("clear", n + 8 > m && n < m + 8, 1);
            host.rd(OFF_STAT);
            check("end", host.rdat[0], 1);
            check("intr", intr, 1);
            host.wr(OFF_IENB, 32'h0);
            repeat (2) @(posedge core_clk);
            check("intr off", intr, 0);
        end
        host.wr(OFF_CONV, 32'h0);
        host.wr(OFF_LSET, 32'h3);
        host.wr(OFF_MSET, 32'h2);
        run(8'h00, CMD_CODE_RUN, 3);
        run(8'h00, CMD_CODE_TSTOP, 4);
        run(8'h00, CMD_CODE_RESTART, 3);
        run(8'h02, CMD_CODE_TSTOP, 2);
        // decoding run ended by the core with a marker
        start(8'h02, CMD_CODE_RUN);
        host.wr(OFF_CTRL, 32'h0303);
        wait_idle();
        host.rd(OFF_STAT);
        check("flags", host.rdat[2:0], 3'h3);
        host.rd(OFF_MDET);
        check("mdet", host.rdat[7:0], MARK_SDRST);
        host.wr(OFF_CTRL, 32'h4);
        host.rd(OFF_STAT);
        check("ovf", host.rdat[2], 1);
        // external context: line count has no say
        start(8'h08, CMD_CODE_RUN);
        repeat (4) host.wr(OFF_LINE, 32'h1);
        check("ext busy", busy, 1);
        host.wr(OFF_CTRL, 32'h1);
        wait_idle();
        check("ext done", busy, 0);
        stop_test();
    end
endmodule
